//--- verilog/mmd_pkg.sv
// Constants, register table and carrier types for the memory map decoder.
// Assumes one 50 MHz clock domain and an APB register port.
package mmd_pkg;

	////////////////////////////////////////////////////////////////////////
	// Address space
	localparam logic [31:0] MMD_SPACE_LO  = 32'h00000000;
	localparam logic [31:0] MMD_SPACE_HI  = 32'hffffffff;
	localparam logic [31:0] MMD_VEC_BASE  = 32'hffffffdc;
	localparam logic [31:0] MMD_RAM_BASE  = 32'h00000400;
	localparam logic [31:0] MMD_SFR0_LO   = 32'h00000000;
	localparam logic [31:0] MMD_SFR0_HI   = 32'h000003ff;
	localparam logic [31:0] MMD_SFR1_LO   = 32'h00040000;
	localparam logic [31:0] MMD_SFR1_HI   = 32'h0004ffff;
	localparam logic [31:0] MMD_ROM_BYTES = 32'h00080000;
	localparam logic [31:0] MMD_RAM_BYTES = 32'h0000fc00;

	////////////////////////////////////////////////////////////////////////
	// Register table; printed offsets are indices, byte address is 4x
	localparam int MMD_NREG = 65;
	localparam int MMD_IW   = 20;

	localparam int MMD_I_CLK  = 0;
	localparam int MMD_I_EBC3 = 3;
	localparam int MMD_I_CHIP_SELECT_BOUNDARY_23 = 4;
	localparam int MMD_I_EBC0 = 9;
	localparam int MMD_I_PBC  = 10;
	localparam int MMD_I_IE0  = 11;
	localparam int MMD_I_SERIAL5_TXRX_CONTROL_0 = 39;
	localparam int MMD_I_PD8  = 54;
	localparam int MMD_I_P10S = 57;

	localparam logic [MMD_IW-1:0] MMD_OFF [MMD_NREG] = '{
		20'h00004, 20'h00006, 20'h00007, 20'h00010, 20'h00012,
		20'h00014, 20'h00016, 20'h00018, 20'h0001a, 20'h0001c,
		20'h0001e, 20'h000b0, 20'h000b1, 20'h000b2, 20'h000b3,
		20'h000b4, 20'h000b5, 20'h000b6, 20'h000b7, 20'h000b8,
		20'h000b9, 20'h000ba, 20'h000bb, 20'h000dd, 20'h000df,
		20'h001a0, 20'h001a2, 20'h001a3, 20'h001a4, 20'h001a5,
		20'h001a6, 20'h001a7, 20'h001c4, 20'h001c5, 20'h001c6,
		20'h001c7, 20'h001c8, 20'h001c9, 20'h001ca, 20'h001cc,
		20'h001cd, 20'h001ce, 20'h00394, 20'h00395, 20'h00396,
		20'h00397, 20'h003c2, 20'h003c3, 20'h003c6, 20'h003c7,
		20'h003ca, 20'h003cb, 20'h003ce, 20'h003cf, 20'h003d2,
		20'h003d3, 20'h003d6, 20'h400f0, 20'h400f2, 20'h400f4,
		20'h400f6, 20'h400f8, 20'h400fa, 20'h400fc, 20'h400fe};

	// Sixteen-bit registers occupy two byte locations
	localparam logic [MMD_NREG-1:0] MMD_W16 = 65'h0_0000_0240_0000_0000 |
		(65'h1 << 3) | (65'h1 << 5) | (65'h1 << 7) | (65'h1 << 9) |
		(65'h1 << 10) | (65'h1 << 25);

	localparam logic [15:0] MMD_RST_CLK  = 16'h0018;
	localparam logic [15:0] MMD_RST_FMC  = 16'h0001;
	localparam logic [15:0] MMD_RST_PBC  = 16'h0504;
	localparam logic [15:0] MMD_RST_SERIAL5_TXRX_CONTROL_0 = 16'h0008;
	localparam logic [15:0] MMD_RST_SERIAL5_TXRX_CONTROL_1 = 16'h0002;
	localparam logic [15:0] MMD_RST_ZERO = 16'h0000;

	// Decoder status and control, beyond the peripheral table
	localparam logic [MMD_IW-1:0] MMD_STAT_IDX = 20'h003e0;
	localparam logic [MMD_IW-1:0] MMD_CTRL_IDX = 20'h003e1;
	localparam int MMD_STAT_RES = 0;
	localparam int MMD_CTRL_BLK = 0;

	////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic rom;
		logic vector;
		logic ram;
		logic peripheral_register_window;
		logic reserved;
	} mmd_sel_t;

	typedef struct packed {
		logic [MMD_NREG-1:0][15:0] regs;
		mmd_sel_t                  sel;
		logic                      res_seen;
		logic                      res_block;
		logic [31:0]               prdata;
		logic                      slverr;
	} mmd_state_t;

endpackage

//--- verilog/mmd_decoder.sv
// Memory map decoder: steers CPU addresses to ROM, vectors, RAM or the
// peripheral register windows, and holds the peripheral control registers.
// Assumes pclk at 50 MHz, APB master for registers, CPU address synchronous.
//
// Overview of operation
// - Decode full 32-bit byte address space.
// - ROM ends at top, grows downward.
// - Vector table occupies topmost ROM locations.
// - RAM starts at 400h, grows upward.
// - RAM takes data and stack accesses alike.
// - Two peripheral register windows decoded.
// - Bus control 0 and 3 reset zero.
// - Three chip-select boundary registers reset zero.
// - Peripheral bus control resets to 0504h.
// - Clock 18h, flash control 01h reset.
// - Twelve event I/O enables reset zero.
// - Serial 7/8 transmit low bits reset.
// - Serial 5 control 0/1 reset 08h/02h.
// - Serial 5 buffers reset, contents undefined.
// - Converter control 2/3 low bits cleared.
// - Port direction registers reset zero.
// - Port 10 function selects at even addresses.
// - Base timer controls reset zero.
`timescale 1ns/1ps
`default_nettype none

module mmd_decoder
	import mmd_pkg::*;
#(
	parameter logic [31:0] ROM_BYTES = MMD_ROM_BYTES,
	parameter logic [31:0] RAM_BYTES = MMD_RAM_BYTES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        cpu_valid,
	input  wire logic [31:0] cpu_addr,
	output mmd_sel_t         dec_sel
);

	////////////////////////////////////////////////////////////////////////
	// Region bounds
	localparam logic [31:0] ROM_BASE = MMD_SPACE_HI - ROM_BYTES + 32'h1;
	localparam logic [31:0] RAM_TOP  = MMD_RAM_BASE + RAM_BYTES - 32'h1;

	mmd_state_t st_r;
	mmd_state_t st_nxt;

	logic                    in_win0;
	logic                    in_win1;
	logic                    occupied;
	logic [MMD_IW-1:0]       cpu_idx;
	logic                    pidx_ok;
	logic [MMD_IW-1:0]       pidx;
	logic [MMD_NREG-1:0]     hit;
	logic                    stat_hit;
	logic                    ctrl_hit;
	logic                    any_hit;
	logic                    wr_go;

	// Zero-wait slave; data was captured in the setup cycle
	assign pready  = 1'b1;
	assign prdata  = st_r.prdata;
	assign pslverr = st_r.slverr & psel & penable;
	assign dec_sel = st_r.sel;

	assign pidx     = paddr[MMD_IW+1:2];
	assign pidx_ok  = (paddr[31:MMD_IW+2] == '0) && (paddr[1:0] == 2'h0);
	assign stat_hit = pidx_ok && (pidx == MMD_STAT_IDX);
	assign ctrl_hit = pidx_ok && (pidx == MMD_CTRL_IDX);
	assign wr_go    = psel & penable & pwrite;
	assign cpu_idx  = cpu_addr[MMD_IW-1:0];

	// Window membership on the whole 32-bit address
	assign in_win0 = (cpu_addr <= MMD_SFR0_HI);
	assign in_win1 = (cpu_addr >= MMD_SFR1_LO) && (cpu_addr <= MMD_SFR1_HI);

	always_comb begin
		hit      = '0;
		occupied = 1'b0;
		for (int i = 0; i < MMD_NREG; i++) begin
			hit[i] = pidx_ok && (pidx == MMD_OFF[i]);
			if (cpu_idx == MMD_OFF[i] ||
			    (MMD_W16[i] && cpu_idx == MMD_OFF[i] + 20'h1))
				occupied = 1'b1;
		end
		any_hit = (|hit) | stat_hit | ctrl_hit;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_nxt = st_r;

		// Address decode, registered one cycle
		st_nxt.sel = '0;
		if (cpu_valid) begin
			if (in_win0 || in_win1) begin
				// Unoccupied window locations flagged, optionally dropped
				st_nxt.sel.reserved = ~occupied;
				st_nxt.sel.peripheral_register_window = occupied | ~st_r.res_block;
			end else if (cpu_addr >= MMD_RAM_BASE &&
			             cpu_addr <= RAM_TOP) begin
				// Reads, writes and stack traffic treated alike
				st_nxt.sel.ram = 1'b1;
			end else if (cpu_addr >= ROM_BASE) begin
				st_nxt.sel.rom    = 1'b1;
				st_nxt.sel.vector = (cpu_addr >= MMD_VEC_BASE);
			end
		end

		// Sticky reserved-access flag; a new hit beats the clear
		if (wr_go && stat_hit && pstrb[0] && pwdata[MMD_STAT_RES])
			st_nxt.res_seen = 1'b0;
		if (st_r.sel.reserved)
			st_nxt.res_seen = 1'b1;

		if (wr_go && ctrl_hit && pstrb[0])
			st_nxt.res_block = pwdata[MMD_CTRL_BLK];

		// Register writes take effect in the access phase
		for (int i = 0; i < MMD_NREG; i++) begin
			if (wr_go && hit[i]) begin
				if (pstrb[0])
					st_nxt.regs[i][7:0] = pwdata[7:0];
				if (pstrb[1] && MMD_W16[i])
					st_nxt.regs[i][15:8] = pwdata[15:8];
			end
		end

		// Read data and error captured in the setup phase
		st_nxt.slverr = 1'b0;
		if (psel && !penable) begin
			st_nxt.prdata = 32'h0;
			st_nxt.slverr = ~any_hit;
			for (int i = 0; i < MMD_NREG; i++) begin
				if (hit[i])
					st_nxt.prdata[15:0] = MMD_W16[i] ? st_r.regs[i] :
						{8'h00, st_r.regs[i][7:0]};
			end
			if (stat_hit)
				st_nxt.prdata[MMD_STAT_RES] = st_r.res_seen;
			if (ctrl_hit)
				st_nxt.prdata[MMD_CTRL_BLK] = st_r.res_block;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register; undefined bits come up as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < MMD_NREG; i++)
				st_r.regs[i] <= MMD_RST_ZERO;
			st_r.regs[MMD_I_CLK]      <= MMD_RST_CLK;
			st_r.regs[MMD_I_CLK + 1]  <= MMD_RST_FMC;
			st_r.regs[MMD_I_PBC]      <= MMD_RST_PBC;
			st_r.regs[MMD_I_SERIAL5_TXRX_CONTROL_0]     <= MMD_RST_SERIAL5_TXRX_CONTROL_0;
			st_r.regs[MMD_I_SERIAL5_TXRX_CONTROL_0 + 1] <= MMD_RST_SERIAL5_TXRX_CONTROL_1;
			// Cleared bits cover those the map requires
			// Likewise converter, port direction and pin selects
			st_r.sel       <= '0;
			st_r.res_seen  <= 1'b0;
			st_r.res_block <= 1'b0;
			st_r.prdata    <= 32'h0;
			st_r.slverr    <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [31:0] pa;
	assign pa = cpu_addr;

	sequence s_wr_clk;
		wr_go && hit[MMD_I_CLK] && pstrb[0];
	endsequence

	a_sel_onehot: assert property (
		$onehot0({dec_sel.rom, dec_sel.ram, dec_sel.peripheral_register_window}))
		else $error("more than one target selected");

	a_rom_range: assert property (
		cpu_valid && pa >= ROM_BASE |=> dec_sel.rom && !dec_sel.ram)
		else $error("ROM address not steered to ROM");

	a_ram_range: assert property (
		cpu_valid && pa >= MMD_RAM_BASE && pa <= RAM_TOP
		|=> dec_sel.ram && !dec_sel.peripheral_register_window)
		else $error("RAM address not steered to RAM");

	a_sfr_window: assert property (
		cpu_valid && (pa <= MMD_SFR0_HI ||
		(pa >= MMD_SFR1_LO && pa <= MMD_SFR1_HI)) && !st_r.res_block
		|=> dec_sel.peripheral_register_window)
		else $error("window address not steered to registers");

	a_vector_top: assert property (
		cpu_valid && pa >= MMD_VEC_BASE
		|=> dec_sel.vector && dec_sel.rom)
		else $error("vector address not in ROM vector area");

	a_no_target: assert property (
		!cpu_valid |=> dec_sel == '0)
		else $error("select without a valid address");

	a_pbc_hold: assert property (
		!(wr_go && hit[MMD_I_PBC]) |=> $stable(st_r.regs[MMD_I_PBC]))
		else $error("peripheral bus control changed without write");

	a_clk_write: assert property (
		s_wr_clk |=> st_r.regs[MMD_I_CLK][7:0] == $past(pwdata[7:0]))
		else $error("clock control write lost");

	a_res_sticky: assert property (
		dec_sel.reserved |=> st_r.res_seen [*2])
		else $error("reserved access not recorded");

	////////////////////////////////////////////////////////////////////////
	// Reset values, checked at the first edge out of reset.
	// Undefined bits are held at zero, so only defined bits are asserted.
	sequence s_rst_exit;
		$rose(presetn);
	endsequence

	a_rst_pbc: assert property (
		s_rst_exit |-> st_r.regs[MMD_I_PBC] == MMD_RST_PBC)
		else $error("peripheral bus control reset value wrong");

	a_rst_clock: assert property (
		s_rst_exit |-> st_r.regs[MMD_I_CLK] == MMD_RST_CLK &&
		st_r.regs[MMD_I_CLK + 1] == MMD_RST_FMC)
		else $error("clock or flash control reset value wrong");

	a_rst_serial: assert property (
		s_rst_exit |-> st_r.regs[MMD_I_SERIAL5_TXRX_CONTROL_0] == MMD_RST_SERIAL5_TXRX_CONTROL_0 &&
		st_r.regs[MMD_I_SERIAL5_TXRX_CONTROL_0 + 1] == MMD_RST_SERIAL5_TXRX_CONTROL_1)
		else $error("serial control reset value wrong");

	a_rst_bus: assert property (
		s_rst_exit |-> st_r.regs[MMD_I_EBC3] == MMD_RST_ZERO &&
		st_r.regs[MMD_I_EBC0] == MMD_RST_ZERO)
		else $error("bus control reset value wrong");

	a_rst_bound: assert property (
		s_rst_exit |-> st_r.regs[MMD_I_CHIP_SELECT_BOUNDARY_23][7:0] == 8'h00 &&
		st_r.regs[MMD_I_CHIP_SELECT_BOUNDARY_23 + 2][7:0] == 8'h00 &&
		st_r.regs[MMD_I_CHIP_SELECT_BOUNDARY_23 + 4][7:0] == 8'h00)
		else $error("chip-select boundary reset value wrong");

	a_rst_irq_en: assert property (
		s_rst_exit |-> st_r.regs[MMD_I_IE0][7:0] == 8'h00 &&
		st_r.regs[MMD_I_IE0 + 11][7:0] == 8'h00)
		else $error("event enable reset value wrong");

	a_rst_serial_tx: assert property (
		s_rst_exit |-> st_r.regs[MMD_I_IE0 + 12][1:0] == 2'h0 &&
		st_r.regs[MMD_I_IE0 + 13][1:0] == 2'h0)
		else $error("serial transmit control reset bits wrong");

	a_rst_timer: assert property (
		s_rst_exit |-> st_r.regs[MMD_I_IE0 + 15][7:0] == 8'h00 &&
		st_r.regs[MMD_I_IE0 + 16][7:0] == 8'h00)
		else $error("base timer control reset value wrong");

	a_rst_conv: assert property (
		s_rst_exit |-> st_r.regs[MMD_I_SERIAL5_TXRX_CONTROL_0 + 3][2:0] == 3'h0 &&
		st_r.regs[MMD_I_SERIAL5_TXRX_CONTROL_0 + 3][5] == 1'b0 &&
		st_r.regs[MMD_I_SERIAL5_TXRX_CONTROL_0 + 4][2:0] == 3'h0)
		else $error("converter control reset bits wrong");

	a_rst_ports: assert property (
		s_rst_exit |-> st_r.regs[MMD_I_PD8][7:0] == 8'h00 &&
		st_r.regs[MMD_I_PD8 - 8][7:0] == 8'h00)
		else $error("port direction reset value wrong");

	a_rst_fsel: assert property (
		s_rst_exit |-> st_r.regs[MMD_I_P10S][7] == 1'b0 &&
		st_r.regs[MMD_I_P10S][2:0] == 3'h0)
		else $error("pin function select reset bits wrong");

	////////////////////////////////////////////////////////////////////////
	// Register port
	a_err_phase: assert property (
		pslverr |-> psel && penable)
		else $error("error outside access phase");

	a_err_unmapped: assert property (
		psel && !penable && !any_hit |=> st_r.slverr)
		else $error("unmapped index not refused");

	a_err_mapped: assert property (
		psel && !penable && any_hit |=> !st_r.slverr)
		else $error("mapped index refused");

	a_wr_refused: assert property (
		wr_go && !any_hit |=> $stable(st_r.regs))
		else $error("write to unmapped index landed");

	a_rd_data: assert property (
		psel && !penable && hit[MMD_I_PBC]
		|=> prdata[15:0] == $past(st_r.regs[MMD_I_PBC]))
		else $error("read data does not match register");

	////////////////////////////////////////////////////////////////////////
	// Decode boundaries; a gap must select nothing at all
	a_rom_floor: assert property (
		cpu_valid && pa < ROM_BASE |=> !dec_sel.rom)
		else $error("ROM selected below its base");

	a_ram_ceiling: assert property (
		cpu_valid && pa > RAM_TOP && pa < MMD_SFR1_LO |=> !dec_sel.ram)
		else $error("RAM selected above its top");

	a_gap_empty: assert property (
		cpu_valid && pa > MMD_SFR1_HI && pa < ROM_BASE |=> dec_sel == '0)
		else $error("gap address selected a target");

	a_vector_rom: assert property (
		dec_sel.vector |-> dec_sel.rom)
		else $error("vector select outside ROM");

	a_block_drop: assert property (
		cpu_valid && (in_win0 || in_win1) && !occupied && st_r.res_block
		|=> !dec_sel.peripheral_register_window && dec_sel.reserved)
		else $error("blocked reserved location still selected");

	a_occupied_sfr: assert property (
		cpu_valid && (in_win0 || in_win1) && occupied
		|=> dec_sel.peripheral_register_window && !dec_sel.reserved)
		else $error("occupied location not selected");

	// Clear works only when no new reserved hit competes with it
	a_res_clear: assert property (
		wr_go && stat_hit && pstrb[0] && pwdata[MMD_STAT_RES] &&
		!st_r.sel.reserved |=> !st_r.res_seen)
		else $error("reserved flag not cleared");

endmodule

`default_nettype wire

//--- tb/mmd_cpu_model.sv
// CPU side model: presents one address per request from the bench.
// Assumes requests change just after a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none

module mmd_cpu_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        go,
	input  wire logic [31:0] addr_in,
	output logic             cpu_valid,
	output logic [31:0]      cpu_addr
);
	// Idle address toggles, so a stale address cannot pass for a match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_valid <= 1'b0;
			cpu_addr  <= 32'h00000000;
		end else begin
			cpu_valid <= go;
			cpu_addr  <= go ? addr_in : ~cpu_addr;
		end
	end
endmodule

`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the memory map decoder.
// Assumes the APB port and the CPU model share pclk.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import mmd_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, go;
	logic        pready, pslverr, cpu_valid;
	logic [31:0] paddr, pwdata, prdata, addr, cpu_addr;
	logic [3:0]  pstrb;
	mmd_sel_t    dec_sel;
	int          fail_count, n_tests, cyc;

	mmd_decoder uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .dec_sel(dec_sel));
	mmd_cpu_model cpu_m (.pclk(pclk), .presetn(presetn), .go(go),
		.addr_in(addr), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr));

	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		if (fail_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	// Index is the printed offset; the byte address is four times it
	task automatic apb(input logic w, input logic [19:0] idx,
		input logic [31:0] d, output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {10'h000, idx, 2'b00};
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [19:0] idx, input logic [31:0] e, m);
		logic [31:0] r;
		logic        er;
		apb(1'b0, idx, 32'h0, r, er);
		chk("prdata", e, r & m);
		chk("pslverr", 32'h0, {31'h0, er});
	endtask

	task automatic cpu(input logic [31:0] a, input logic v, input mmd_sel_t e);
		@(posedge pclk);
		go   <= v;
		addr <= a;
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
		#1;
		chk("dec_sel", {27'h0, e}, {27'h0, dec_sel});
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset_values();
		rchk(20'h00004, 32'h18, 32'hff);
		rchk(20'h00006, 32'h01, 32'hff);
		rchk(20'h00010, 32'h0, 32'hffff);
		rchk(20'h0001c, 32'h0, 32'hffff);
		rchk(20'h00012, 32'h0, 32'hff);
		rchk(20'h00016, 32'h0, 32'hff);
		rchk(20'h0001a, 32'h0, 32'hff);
		rchk(20'h0001e, 32'h504, 32'hffff);
		rchk(20'h000b0, 32'h0, 32'hff);
		rchk(20'h000bb, 32'h0, 32'hff);
		rchk(20'h000dd, 32'h0, 32'h03);
		rchk(20'h000df, 32'h0, 32'h03);
		rchk(20'h001cc, 32'h08, 32'hff);
		rchk(20'h001cd, 32'h02, 32'hff);
		rchk(20'h00394, 32'h0, 32'h27);
		rchk(20'h00395, 32'h0, 32'h07);
		rchk(20'h003c2, 32'h0, 32'hff);
		rchk(20'h003d2, 32'h0, 32'hdf);
		rchk(20'h400f0, 32'h0, 32'h87);
		rchk(20'h400fe, 32'h0, 32'h87);
		rchk(20'h001a2, 32'h0, 32'hff);
		rchk(20'h001a3, 32'h0, 32'hff);
	endtask

	// Reserved index: write dropped, error flagged both ways
	task automatic t_write_refused();
		logic [31:0] r;
		logic        er;
		apb(1'b1, 20'h0001e, 32'h1234, r, er);
		rchk(20'h0001e, 32'h1234, 32'hffffffff);
		apb(1'b1, 20'h00004, 32'ha5a5, r, er);
		rchk(20'h00004, 32'ha5, 32'hffffffff);
		apb(1'b1, 20'h00005, 32'hff, r, er);
		chk("pslverr", 32'h1, {31'h0, er});
		apb(1'b0, 20'h00005, 32'h0, r, er);
		chk("pslverr", 32'h1, {31'h0, er});
		chk("prdata", 32'h0, r);
	endtask

	task automatic t_decode();
		logic [31:0] r;
		logic        er;
		cpu(32'hfff80000, 1'b1, 5'h10);
		cpu(32'hfff7ffff, 1'b1, 5'h00);
		cpu(32'hffffffdc, 1'b1, 5'h18);
		cpu(32'hffffffdb, 1'b1, 5'h10);
		cpu(32'hffffffff, 1'b1, 5'h18);
		cpu(32'h00000400, 1'b1, 5'h04);
		cpu(32'h0000ffff, 1'b1, 5'h04);
		cpu(32'h00010000, 1'b1, 5'h00);
		cpu(32'h00000004, 1'b1, 5'h02);
		cpu(32'h00000011, 1'b1, 5'h02);
		cpu(32'h00000000, 1'b1, 5'h03);
		cpu(32'h000003ff, 1'b1, 5'h03);
		cpu(32'h0003ffff, 1'b1, 5'h00);
		cpu(32'h00040000, 1'b1, 5'h03);
		cpu(32'h000400f0, 1'b1, 5'h02);
		cpu(32'h000400f1, 1'b1, 5'h03);
		cpu(32'h0004ffff, 1'b1, 5'h03);
		cpu(32'h00050000, 1'b1, 5'h00);
		cpu(32'hfff80000, 1'b0, 5'h00);
		rchk(MMD_STAT_IDX, 32'h1, 32'h1);
		apb(1'b1, MMD_STAT_IDX, 32'h1, r, er);
		rchk(MMD_STAT_IDX, 32'h0, 32'h1);
		apb(1'b1, MMD_CTRL_IDX, 32'h1, r, er);
		rchk(MMD_CTRL_IDX, 32'h1, 32'h1);
		cpu(32'h00000000, 1'b1, 5'h01);
		cpu(32'h00000004, 1'b1, 5'h02);
		apb(1'b1, MMD_CTRL_IDX, 32'h0, r, er);
		cpu(32'h00000000, 1'b1, 5'h03);
	endtask

	// Mid-run reset must restore the peripheral bus control and clock reset values
	task automatic t_second_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rchk(20'h0001e, 32'h504, 32'hffff);
		rchk(20'h00004, 32'h18, 32'hff);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			conclude();
		end
	end

	initial begin
		presetn    = 1'b0;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 32'h0;
		pwdata     = 32'h0;
		pstrb      = 4'hf;
		go         = 1'b0;
		addr       = 32'h0;
		fail_count = 0;
		n_tests    = 0;
		cyc        = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_values();
		t_write_refused();
		t_decode();
		t_second_reset();
		conclude();
	end
endmodule

`default_nettype wire
